// [sbw_addon_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Stacked add-on modules: one jumpered slot card, one display card
module sbw_addon_model #(
  parameter logic [2:0] SLOT = 3'h1   // Jumpers A22..A20, OFF reads 1
) (
  input  wire sbw_pkg::sbw_strb_t strb,     // Bus strobes, active low
  input  wire logic [23:0]        addr,     // Bus address lines
  output logic                    hit,      // Slot card selected
  output logic                    disp_hit  // Display card selected
);
  logic mem_on;
  assign mem_on = !(strb.mem_space_read_strobe_n &&
                    strb.mem_space_write_strobe_n);
  // All-ON slot overlaps display and reserved space, so it never answers
  assign hit = (SLOT != 3'h0) && mem_on && (addr[23] == 1'h0) &&
               (addr[22:20] == SLOT);
  assign disp_hit = mem_on && (addr[23:19] == 5'h00);
endmodule
`default_nettype wire

// [sbw_decoder.sv]
// Operation
// - Strobes only inside the 16 MB window
// - Memory strobes only in lower half
// - I/O strobes only in upper half
// - Decoded half picks the strobe pair
// - All four strobes are active low
// - 24-bit memory, 16-bit I/O, 8/16 data
// - 64 KB I/O repeats over upper half
// - 0x10mn_03xx, with m of 8 to f, reaches I/O 0x03xx
// - Logic makes strobes processor cannot make
`timescale 1ns/1ns
`default_nettype none

module sbw_decoder (
  input  wire logic               REF_CLK,    // 25 MHz local bus clock
  input  wire logic               RESET,      // Synchronous, active high
  input  wire sbw_pkg::sbw_req_t  CPU_REQ,    // Processor address, rd, wr
  output var  sbw_pkg::sbw_strb_t BUS_STRB,   // Expansion strobes, low
  output var  logic [23:0]        BUS_ADDR,   // Expansion address lines
  output var  logic               BUS_WIDE    // 16-bit transfer
);

  // ==========================================================
  // Decoding
  function automatic sbw_pkg::sbw_space_t space_of(
    input logic [31:0] addr
  );
    if (addr >= sbw_pkg::WIN_FIRST && addr <= sbw_pkg::MEM_LAST) begin
      space_of = sbw_pkg::SP_MEM;
    end else if (addr >= sbw_pkg::IO_FIRST &&
                 addr <= sbw_pkg::WIN_LAST) begin
      space_of = sbw_pkg::SP_IO;
    end else begin
      space_of = sbw_pkg::SP_NONE;
    end
  endfunction

  // Bus address for a space: I/O drops upper bits so 64 KB repeats
  function automatic logic [23:0] bus_addr_of(
    input logic [31:0]        addr,
    input sbw_pkg::sbw_space_t sp
  );
    if (sp == sbw_pkg::SP_IO) begin
      bus_addr_of = {8'h00, addr[sbw_pkg::IO_ADDR_W-1:0]};
    end else begin
      bus_addr_of = addr[sbw_pkg::MEM_ADDR_W-1:0];
    end
  endfunction

  // ==========================================================
  // Cycle sequencer
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACTIVE,
    ST_RECOVER
  } sbw_state_t;

  sbw_state_t          state;
  sbw_state_t          next_state;
  sbw_pkg::sbw_strb_t  next_strb;
  logic [23:0]         next_addr;
  logic                next_wide;
  sbw_pkg::sbw_space_t req_space;
  logic                req_valid;

  assign req_space = space_of(CPU_REQ.addr);
  // Read and write together is ambiguous, so it is not started
  assign req_valid = CPU_REQ.rd ^ CPU_REQ.wr;

  always_comb begin
    next_state = state;
    next_strb  = BUS_STRB;
    next_addr  = BUS_ADDR;
    next_wide  = BUS_WIDE;
    case (state)
      ST_IDLE: begin
        if (req_valid && req_space != sbw_pkg::SP_NONE) begin
          next_state = ST_ACTIVE;
          // Address and strobe leave on the same edge and the address
          // then holds, so the module never sees it move under a strobe
          next_addr  = bus_addr_of(CPU_REQ.addr, req_space);
          next_wide  = CPU_REQ.wide;
          next_strb  = sbw_pkg::STRB_RST;
          if (req_space == sbw_pkg::SP_MEM) begin
            next_strb.mem_space_read_strobe_n  = ~CPU_REQ.rd;
            next_strb.mem_space_write_strobe_n = ~CPU_REQ.wr;
          end else begin
            next_strb.io_space_read_strobe_n   = ~CPU_REQ.rd;
            next_strb.io_space_write_strobe_n  = ~CPU_REQ.wr;
          end
        end
      end
      ST_ACTIVE: begin
        if (!CPU_REQ.rd && !CPU_REQ.wr) begin
          next_state = ST_RECOVER;
          next_strb  = sbw_pkg::STRB_RST;
        end
      end
      ST_RECOVER: begin
        // One idle cycle keeps two strobes from running together
        next_state = ST_IDLE;
        next_strb  = sbw_pkg::STRB_RST;
      end
      default: begin
        next_state = ST_IDLE;
        next_strb  = sbw_pkg::STRB_RST;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state    <= ST_IDLE;
      BUS_STRB <= sbw_pkg::STRB_RST;
      BUS_ADDR <= sbw_pkg::ADDR_RST;
      BUS_WIDE <= sbw_pkg::WIDE_RST;
    end else begin
      state    <= next_state;
      BUS_STRB <= next_strb;
      BUS_ADDR <= next_addr;
      BUS_WIDE <= next_wide;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  logic mem_on;
  logic io_on;
  assign mem_on = !BUS_STRB.mem_space_read_strobe_n ||
                  !BUS_STRB.mem_space_write_strobe_n;
  assign io_on  = !BUS_STRB.io_space_read_strobe_n ||
                  !BUS_STRB.io_space_write_strobe_n;

  property p_outside_quiet;
    (state == ST_IDLE && space_of(CPU_REQ.addr) == sbw_pkg::SP_NONE)
      |=> !mem_on && !io_on;
  endproperty
  a_outside_quiet: assert property (p_outside_quiet)
    else $error("Strobe asserted for an address outside the window");

  property p_mem_half;
    $rose(mem_on) |-> $past(space_of(CPU_REQ.addr)) == sbw_pkg::SP_MEM;
  endproperty
  a_mem_half: assert property (p_mem_half)
    else $error("Memory strobe started outside the lower half");

  property p_io_half;
    $rose(io_on) |-> $past(space_of(CPU_REQ.addr)) == sbw_pkg::SP_IO;
  endproperty
  a_io_half: assert property (p_io_half)
    else $error("I/O strobe started outside the upper half");

  property p_pair_select;
    (state == ST_IDLE && CPU_REQ.rd && !CPU_REQ.wr &&
     space_of(CPU_REQ.addr) == sbw_pkg::SP_MEM)
      |=> !BUS_STRB.mem_space_read_strobe_n && !io_on;
  endproperty
  a_pair_select: assert property (p_pair_select)
    else $error("Memory read did not select the memory strobe pair");

  property p_low_active;
    (state == ST_IDLE && CPU_REQ.wr && !CPU_REQ.rd &&
     space_of(CPU_REQ.addr) == sbw_pkg::SP_IO)
      |=> BUS_STRB == 4'hd;
  endproperty
  a_low_active: assert property (p_low_active)
    else $error("I/O write strobe not driven low alone");

  property p_io_alias;
    $rose(io_on) |-> BUS_ADDR[23:16] == 8'h00;
  endproperty
  a_io_alias: assert property (p_io_alias)
    else $error("I/O cycle carried address bits above 16");

  property p_io_offset;
    $rose(io_on) |-> BUS_ADDR[15:0] == $past(CPU_REQ.addr[15:0]);
  endproperty
  a_io_offset: assert property (p_io_offset)
    else $error("I/O bus address differs from processor low bits");

  property p_mem_addr;
    $rose(mem_on) |-> BUS_ADDR == $past(CPU_REQ.addr[23:0]);
  endproperty
  a_mem_addr: assert property (p_mem_addr)
    else $error("Memory bus address differs from processor bits");

  property p_strobe_ends;
    (state == ST_ACTIVE && !CPU_REQ.rd && !CPU_REQ.wr)
      |=> !mem_on && !io_on ##1 state == ST_IDLE;
  endproperty
  a_strobe_ends: assert property (p_strobe_ends)
    else $error("Strobe did not end after the processor released");

  property p_addr_stable;
    (mem_on || io_on) && $past(mem_on || io_on)
      |-> $stable(BUS_ADDR);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("Bus address moved while a strobe was asserted");

  property p_one_space;
    !(mem_on && io_on);
  endproperty
  a_one_space: assert property (p_one_space)
    else $error("Memory and I/O strobes asserted together");

  property p_recover_quiet;
    state == ST_RECOVER |-> !mem_on && !io_on;
  endproperty
  a_recover_quiet: assert property (p_recover_quiet)
    else $error("Strobe asserted during the recovery cycle");

  property p_both_refused;
    (state == ST_IDLE && CPU_REQ.rd && CPU_REQ.wr)
      |=> !mem_on && !io_on;
  endproperty
  a_both_refused: assert property (p_both_refused)
    else $error("Read and write together started a strobe");

endmodule

`default_nettype wire

// [sbw_pkg.sv]
// ============================================================
// Window decoder constants and types
`default_nettype none
package sbw_pkg;

  // ==========================================================
  // Address window
  localparam logic [31:0] WIN_FIRST  = 32'h1000_0000;
  localparam logic [31:0] WIN_LAST   = 32'h10ff_ffff;
  localparam logic [31:0] MEM_LAST   = 32'h107f_ffff;
  localparam logic [31:0] IO_FIRST   = 32'h1080_0000;

  // ==========================================================
  // Bus address widths per space
  localparam int          MEM_ADDR_W = 24;
  localparam int          IO_ADDR_W  = 16;

  // ==========================================================
  // Values after reset
  localparam logic [23:0] ADDR_RST   = 24'h00_0000;
  localparam logic        STRB_IDLE  = 1'h1;
  localparam logic        WIDE_RST   = 1'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SP_NONE,
    SP_MEM,
    SP_IO
  } sbw_space_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        rd;
    logic        wr;
    logic        wide;
  } sbw_req_t;

  typedef struct packed {
    logic mem_space_write_strobe_n;
    logic mem_space_read_strobe_n;
    logic io_space_write_strobe_n;
    logic io_space_read_strobe_n;
  } sbw_strb_t;

  localparam sbw_strb_t STRB_RST = '{STRB_IDLE, STRB_IDLE,
                                     STRB_IDLE, STRB_IDLE};

endpackage

`default_nettype wire

// [stack_bus_window_decoder_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module stack_bus_window_decoder_tb;
  logic               ref_clk = 1'h0;
  logic               reset   = 1'h1;
  sbw_pkg::sbw_req_t  req     = '0;
  sbw_pkg::sbw_strb_t strb;
  logic [23:0]        baddr;
  logic               bwide;
  logic               hit;
  logic               disp_hit;
  int                 mismatches = 0;
  int                 n_checks = 0;

  always #20 ref_clk = ~ref_clk;

  sbw_decoder i_sbw_decoder (.REF_CLK(ref_clk), .RESET(reset),
    .CPU_REQ(req), .BUS_STRB(strb), .BUS_ADDR(baddr), .BUS_WIDE(bwide));
  sbw_addon_model i_sbw_addon_model (.strb(strb), .addr(baddr),
    .hit(hit), .disp_hit(disp_hit));

  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ==========================================================
  // One access: request, hold one cycle, release, wait recovery
  task automatic run_cyc(input logic [31:0] a, input logic r,
      input logic w, input logic wd, input logic [3:0] es,
      input logic [23:0] ea, input logic [1:0] eh);
    req = '{a, r, w, wd};
    @(negedge ref_clk);
    chk("strobes", {20'h0, es}, {20'h0, strb});
    chk("cards", {22'h0, eh}, {22'h0, disp_hit, hit});
    if (es != 4'hf) begin
      chk("address", ea, baddr);
      chk("wide", {23'h0, wd}, {23'h0, bwide});
    end
    req.rd = 1'h0;
    req.wr = 1'h0;
    @(negedge ref_clk);
    chk("released", 24'hf, {20'h0, strb});
    @(negedge ref_clk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_mem;
    run_cyc(32'h1012_3456, 1'h1, 1'h0, 1'h1, 4'hb, 24'h12_3456, 2'h1);
    run_cyc(32'h107f_ffff, 1'h0, 1'h1, 1'h0, 4'h7, 24'h7f_ffff, 2'h0);
    run_cyc(32'h1000_0010, 1'h1, 1'h0, 1'h0, 4'hb, 24'h00_0010, 2'h2);
    run_cyc(32'h1008_0000, 1'h1, 1'h0, 1'h0, 4'hb, 24'h08_0000, 2'h0);
  endtask

  task automatic t_io;
    run_cyc(32'h10a5_0300, 1'h0, 1'h1, 1'h0, 4'hd, 24'h00_0300, 2'h0);
    run_cyc(32'h10ff_03ff, 1'h1, 1'h0, 1'h1, 4'he, 24'h00_03ff, 2'h0);
    run_cyc(32'h1080_0000, 1'h1, 1'h0, 1'h0, 4'he, 24'h00_0000, 2'h0);
    run_cyc(32'h10ff_ffff, 1'h0, 1'h1, 1'h1, 4'hd, 24'h00_ffff, 2'h0);
  endtask

  // Edges of the window and a read with write both refused
  task automatic t_refuse;
    run_cyc(32'h0fff_ffff, 1'h1, 1'h0, 1'h0, 4'hf, 24'h0, 2'h0);
    run_cyc(32'h1100_0000, 1'h0, 1'h1, 1'h0, 4'hf, 24'h0, 2'h0);
    run_cyc(32'h1010_0000, 1'h1, 1'h1, 1'h0, 4'hf, 24'h0, 2'h0);
  endtask

  // Held access ignores changes, early request waits out recovery,
  // then a reset in mid-run cuts an active strobe
  task automatic t_hold;
    req = '{32'h1010_0000, 1'h1, 1'h0, 1'h1};
    repeat (3) @(negedge ref_clk);
    req = '{32'h10a5_0300, 1'h0, 1'h1, 1'h1};
    @(negedge ref_clk);
    chk("held strobes", 24'hb, {20'h0, strb});
    chk("held address", 24'h10_0000, baddr);
    chk("held card", 24'h1, {22'h0, disp_hit, hit});
    req.wr = 1'h0;
    @(negedge ref_clk);
    chk("hold released", 24'hf, {20'h0, strb});
    req.wr = 1'h1;
    @(negedge ref_clk);
    chk("recovery", 24'hf, {20'h0, strb});
    @(negedge ref_clk);
    chk("after recovery", 24'hd, {20'h0, strb});
    chk("io address", 24'h00_0300, baddr);
    chk("io wide", 24'h1, {23'h0, bwide});
    reset = 1'h1;
    @(negedge ref_clk);
    chk("cut strobes", 24'hf, {20'h0, strb});
    chk("cut address", sbw_pkg::ADDR_RST, baddr);
    chk("cut wide", 24'h0, {23'h0, bwide});
    reset = 1'h0;
    req.wr = 1'h0;
    repeat (2) @(negedge ref_clk);
    chk("after reset", 24'hf, {20'h0, strb});
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run is under 60 cycles; the guard leaves wide margin
  initial begin
    repeat (2000) @(posedge ref_clk);
    mismatches++;
    test_done();
  end

  initial begin
    repeat (2) @(negedge ref_clk);
    reset = 1'h0;
    chk("reset strobes", 24'hf, {20'h0, strb});
    chk("reset address", sbw_pkg::ADDR_RST, baddr);
    chk("reset wide", 24'h0, {23'h0, bwide});
    t_mem();
    t_io();
    t_refuse();
    t_hold();
    test_done();
  end
endmodule
`default_nettype wire
